// File: include/efac_pkg.sv
// Constants, register map and carrier types for exposure, frame and readout window control
`default_nettype none
package efac_pkg;
   localparam int CLOCK_HZ = 20_000_000;
   localparam int CYCLES_PER_US = CLOCK_HZ / 1_000_000;
   localparam int ROW_GAP_NS = 1000;
   localparam int ROW_GAP_CYCLES = (ROW_GAP_NS * CYCLES_PER_US + 999) / 1000;
   localparam int US_W = 20;
   localparam int DIM_W = 13;
   localparam int PIX_W = 12;
   localparam int ACC_W = 24;
   localparam int FIFO_DEPTH = 32;

   // Sensor geometry and window presets
   localparam logic [DIM_W-1:0] SENSOR_W = 13'h1400;
   localparam logic [DIM_W-1:0] SENSOR_H = 13'h1400;
   localparam logic [DIM_W-1:0] QHD_W = 13'h0F00;
   localparam logic [DIM_W-1:0] QHD_H = 13'h0870;
   localparam logic [DIM_W-1:0] QHD_X = (SENSOR_W - QHD_W) / 2;
   localparam logic [DIM_W-1:0] QHD_Y = (SENSOR_H - QHD_H) / 2;
   localparam logic [DIM_W-1:0] ZERO_DIM = 13'h0000;

   // Limits and reset values
   localparam logic [US_W-1:0] FRAME_US_MAX = 20'hF_4240;
   localparam logic [US_W-1:0] FRAME_US_RESET = 20'h1_86A0;
   localparam logic [US_W-1:0] EXPOSURE_US_RESET = 20'h0_2710;
   localparam logic [6:0] PCLK_MIN = 7'h20;
   localparam logic [6:0] PCLK_MAX = 7'h71;
   localparam logic [6:0] PCLK_RESET = 7'h64;
   localparam logic [7:0] CYC_PER_US_8 = 8'(CYCLES_PER_US);

   // Register byte addresses
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_EXPOSURE = 8'h04;
   localparam logic [7:0] ADDR_FRAME = 8'h08;
   localparam logic [7:0] ADDR_PCLK = 8'h0C;
   localparam logic [7:0] ADDR_WIN_X = 8'h10;
   localparam logic [7:0] ADDR_WIN_Y = 8'h14;
   localparam logic [7:0] ADDR_WIN_W = 8'h18;
   localparam logic [7:0] ADDR_WIN_H = 8'h1C;
   localparam logic [7:0] ADDR_MAX_EXP = 8'h20;
   localparam logic [7:0] ADDR_PULSE_US = 8'h24;
   localparam logic [7:0] ADDR_PERIOD_US = 8'h28;

   // Control register fields
   localparam int CTL_MODE_LSB = 0;
   localparam int CTL_FT_EN = 2;
   localparam int CTL_ZERO_GAP = 3;
   localparam int CTL_WIN_LSB = 4;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;

   typedef enum logic [1:0] {
      EFAC_EXP_OFF = 2'h0,
      EFAC_EXP_PULSE = 2'h1,
      EFAC_EXP_INTERNAL = 2'h2
   } efac_exp_mode_type;

   typedef enum logic [1:0] {
      EFAC_WIN_FULL = 2'h0,
      EFAC_WIN_QHD = 2'h1,
      EFAC_WIN_CUSTOM = 2'h2
   } efac_win_type;

   typedef struct packed {
      logic [PIX_W-1:0] data;
      logic first;
      logic line_end;
   } efac_pixel_type;

   typedef struct packed {
      logic [DIM_W-1:0] x;
      logic [DIM_W-1:0] y;
      logic [DIM_W-1:0] w;
      logic [DIM_W-1:0] h;
   } efac_window_type;
endpackage : efac_pkg
`default_nettype wire

// File: rtl/efac_fifo.sv
// Synchronous valid/ready FIFO with parameter width and depth
`default_nettype none
module efac_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 32
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = count != (AW+1)'(DEPTH);
   assign out_valid = count != '0;
   assign out_data = store[rd_ptr];

   always_ff @(posedge clock) begin
      if (push) begin
         store[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : efac_fifo
`default_nettype wire

// File: rtl/efac_control.sv
// Exposure, frame timing, line timing and readout window control with AHB-Lite registers
`default_nettype none
module efac_control (
   input wire logic clock,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic trigger_in,
   output logic exposure_active,
   output logic frame_start,
   output logic readout_active,
   output logic line_done,
   input wire logic pix_valid,
   output logic pix_ready,
   input wire efac_pkg::efac_pixel_type pix_in,
   output logic out_valid,
   input wire logic out_ready,
   output efac_pkg::efac_pixel_type out_pixel
);
   // Register file
   logic [31:0] control;
   logic [efac_pkg::US_W-1:0] exposure_us;
   logic [efac_pkg::US_W-1:0] frame_us;
   logic [6:0] pclk_mhz;
   efac_pkg::efac_window_type custom_win;
   logic [efac_pkg::US_W-1:0] pulse_us;
   logic [efac_pkg::US_W-1:0] period_us;

   // Bus data phase state
   logic wr_pending;
   logic [7:0] wr_addr;

   wire bus_valid = hsel && hready && (htrans == efac_pkg::HTRANS_NONSEQ || htrans == efac_pkg::HTRANS_SEQ);
   wire bus_write = bus_valid && hwrite;
   wire bus_read = bus_valid && !hwrite;
   wire [7:0] addr_low = haddr[7:0];
   wire addr_high_ok = haddr[31:8] == 24'h00_0000;

   wire efac_pkg::efac_exp_mode_type exp_mode = efac_pkg::efac_exp_mode_type'(control[efac_pkg::CTL_MODE_LSB +: 2]);
   wire ft_enable = control[efac_pkg::CTL_FT_EN];
   wire zero_gap = control[efac_pkg::CTL_ZERO_GAP];
   wire efac_pkg::efac_win_type win_sel = efac_pkg::efac_win_type'(control[efac_pkg::CTL_WIN_LSB +: 2]);

   // Active window from preset or custom registers
   efac_pkg::efac_window_type win;
   assign win = (win_sel == efac_pkg::EFAC_WIN_FULL) ?
                '{efac_pkg::ZERO_DIM, efac_pkg::ZERO_DIM, efac_pkg::SENSOR_W, efac_pkg::SENSOR_H} :
                (win_sel == efac_pkg::EFAC_WIN_QHD) ?
                '{efac_pkg::QHD_X, efac_pkg::QHD_Y, efac_pkg::QHD_W, efac_pkg::QHD_H} :
                custom_win;

   // Exposure limit follows programmed or measured frame time
   wire [efac_pkg::US_W-1:0] max_exposure = ft_enable ? frame_us : period_us;
   wire [efac_pkg::US_W-1:0] eff_exposure = (exposure_us > max_exposure) ? max_exposure : exposure_us;

   // Write value limits
   wire [efac_pkg::US_W-1:0] wr_frame = (hwdata[31:efac_pkg::US_W] != '0 ||
                                          hwdata[efac_pkg::US_W-1:0] > efac_pkg::FRAME_US_MAX) ?
                                         efac_pkg::FRAME_US_MAX : hwdata[efac_pkg::US_W-1:0];
   wire [6:0] wr_pclk = (hwdata[31:7] != '0 || hwdata[6:0] > efac_pkg::PCLK_MAX) ? efac_pkg::PCLK_MAX :
                        (hwdata[6:0] < efac_pkg::PCLK_MIN) ? efac_pkg::PCLK_MIN : hwdata[6:0];

   logic [31:0] read_mux;
   always_comb begin
      read_mux = 32'h0000_0000;
      if (addr_high_ok) begin
         unique case (addr_low)
            efac_pkg::ADDR_CONTROL: read_mux = control;
            efac_pkg::ADDR_EXPOSURE: read_mux = 32'(exposure_us);
            efac_pkg::ADDR_FRAME: read_mux = 32'(frame_us);
            efac_pkg::ADDR_PCLK: read_mux = 32'(pclk_mhz);
            efac_pkg::ADDR_WIN_X: read_mux = 32'(custom_win.x);
            efac_pkg::ADDR_WIN_Y: read_mux = 32'(custom_win.y);
            efac_pkg::ADDR_WIN_W: read_mux = 32'(custom_win.w);
            efac_pkg::ADDR_WIN_H: read_mux = 32'(custom_win.h);
            efac_pkg::ADDR_MAX_EXP: read_mux = 32'(max_exposure);
            efac_pkg::ADDR_PULSE_US: read_mux = 32'(pulse_us);
            efac_pkg::ADDR_PERIOD_US: read_mux = 32'(period_us);
            default: read_mux = 32'h0000_0000;
         endcase
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge clock) begin
      if (reset) begin
         wr_pending <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= 32'h0000_0000;
      end else begin
         wr_pending <= bus_write && addr_high_ok;
         wr_addr <= addr_low;
         if (bus_read) begin
            hrdata <= read_mux;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         control <= efac_pkg::CONTROL_RESET;
         exposure_us <= efac_pkg::EXPOSURE_US_RESET;
         frame_us <= efac_pkg::FRAME_US_RESET;
         pclk_mhz <= efac_pkg::PCLK_RESET;
         custom_win <= '{efac_pkg::ZERO_DIM, efac_pkg::ZERO_DIM, efac_pkg::SENSOR_W, efac_pkg::SENSOR_H};
      end else if (wr_pending) begin
         unique case (wr_addr)
            efac_pkg::ADDR_CONTROL: control <= {26'h000_0000, hwdata[5:0]};
            efac_pkg::ADDR_EXPOSURE: exposure_us <= hwdata[efac_pkg::US_W-1:0];
            efac_pkg::ADDR_FRAME: frame_us <= wr_frame;
            efac_pkg::ADDR_PCLK: pclk_mhz <= wr_pclk;
            efac_pkg::ADDR_WIN_X: custom_win.x <= hwdata[efac_pkg::DIM_W-1:0];
            efac_pkg::ADDR_WIN_Y: custom_win.y <= hwdata[efac_pkg::DIM_W-1:0];
            efac_pkg::ADDR_WIN_W: custom_win.w <= hwdata[efac_pkg::DIM_W-1:0];
            efac_pkg::ADDR_WIN_H: custom_win.h <= hwdata[efac_pkg::DIM_W-1:0];
            default: ;
         endcase
      end
   end

   // Microsecond tick
   logic [7:0] us_div;
   wire us_tick = us_div == efac_pkg::CYC_PER_US_8 - 8'h01;
   always_ff @(posedge clock) begin
      if (reset || us_tick) begin
         us_div <= 8'h00;
      end else begin
         us_div <= us_div + 8'h01;
      end
   end

   // Frame and line timing
   typedef enum logic [2:0] {
      EFAC_ST_LINE = 3'b001,
      EFAC_ST_GAP = 3'b010,
      EFAC_ST_HOLD = 3'b100
   } efac_state_type;

   efac_state_type state;
   efac_state_type next_state;
   logic [efac_pkg::ACC_W-1:0] line_acc;
   logic [7:0] gap_count;
   logic [efac_pkg::DIM_W-1:0] line_count;
   logic [efac_pkg::US_W-1:0] frame_elapsed;

   // A line lasts width/pclk us: accumulate pclk each cycle against width in pixel-cycles
   wire [efac_pkg::ACC_W-1:0] line_target = efac_pkg::ACC_W'(win.w) * efac_pkg::ACC_W'(efac_pkg::CYCLES_PER_US);
   wire [efac_pkg::ACC_W-1:0] next_acc = line_acc + efac_pkg::ACC_W'(pclk_mhz);
   wire line_pixels_done = (state == EFAC_ST_LINE) && (next_acc >= line_target);
   wire last_line = line_count + 1'b1 >= win.h;
   wire gap_done = gap_count == 8'(efac_pkg::ROW_GAP_CYCLES - 1);
   assign line_done = line_pixels_done ? zero_gap : ((state == EFAC_ST_GAP) && gap_done);
   wire readout_end = line_done && last_line;
   wire hold_over = frame_elapsed + 1'b1 >= frame_us;
   wire hold_end = (state == EFAC_ST_HOLD) && us_tick && hold_over;
   wire need_hold = ft_enable && !hold_over;
   wire frame_end = (readout_end && !need_hold) || hold_end;

   always_comb begin
      next_state = state;
      unique case (state)
         EFAC_ST_LINE: begin
            if (line_pixels_done && !zero_gap) begin
               next_state = EFAC_ST_GAP;
            end else if (readout_end && need_hold) begin
               next_state = EFAC_ST_HOLD;
            end
         end
         EFAC_ST_GAP: begin
            if (gap_done) begin
               next_state = (last_line && need_hold) ? EFAC_ST_HOLD : EFAC_ST_LINE;
            end
         end
         EFAC_ST_HOLD: begin
            if (hold_end) begin
               next_state = EFAC_ST_LINE;
            end
         end
         default: next_state = EFAC_ST_LINE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state <= EFAC_ST_LINE;
         line_acc <= '0;
         gap_count <= 8'h00;
         line_count <= '0;
         frame_elapsed <= '0;
         period_us <= efac_pkg::FRAME_US_RESET;
         frame_start <= 1'b1;
      end else begin
         state <= next_state;
         line_acc <= (state == EFAC_ST_LINE && !line_pixels_done) ? next_acc : '0;
         gap_count <= (state == EFAC_ST_GAP && !gap_done) ? gap_count + 8'h01 : 8'h00;
         line_count <= frame_end ? '0 : (line_done ? line_count + 1'b1 : line_count);
         frame_start <= frame_end;
         if (frame_end) begin
            frame_elapsed <= '0;
            period_us <= frame_elapsed + efac_pkg::US_W'(us_tick);
         end else if (us_tick) begin
            frame_elapsed <= frame_elapsed + 1'b1;
         end
      end
   end

   assign readout_active = state != EFAC_ST_HOLD;

   // Exposure generation and pulse width measurement
   logic trig_prev;
   logic [efac_pkg::US_W-1:0] pulse_count;
   always_ff @(posedge clock) begin
      if (reset) begin
         trig_prev <= 1'b0;
         pulse_count <= '0;
         pulse_us <= '0;
      end else begin
         trig_prev <= trigger_in;
         if (trigger_in && !trig_prev) begin
            // A tick in the rising cycle already belongs to the pulse
            pulse_count <= efac_pkg::US_W'(us_tick);
         end else if (trigger_in && us_tick) begin
            pulse_count <= pulse_count + 1'b1;
         end
         if (!trigger_in && trig_prev) begin
            pulse_us <= pulse_count;
         end
      end
   end

   logic internal_exp;
   assign internal_exp = frame_elapsed < eff_exposure;
   assign exposure_active = (exp_mode == efac_pkg::EFAC_EXP_PULSE) ? trigger_in :
                            (exp_mode == efac_pkg::EFAC_EXP_INTERNAL) ? internal_exp :
                            1'b1;

   // Pixel window crop, coordinates start at (1, 1)
   logic [efac_pkg::DIM_W-1:0] col;
   logic [efac_pkg::DIM_W-1:0] row;
   wire [efac_pkg::DIM_W-1:0] cur_col = pix_in.first ? efac_pkg::DIM_W'(1) : col;
   wire [efac_pkg::DIM_W-1:0] cur_row = pix_in.first ? efac_pkg::DIM_W'(1) : row;
   wire in_x = cur_col > win.x && cur_col <= win.x + win.w;
   wire in_y = cur_row > win.y && cur_row <= win.y + win.h;
   wire in_window = in_x && in_y;
   wire fifo_ready;
   wire pix_take = pix_valid && pix_ready;
   efac_pkg::efac_pixel_type crop_pixel;
   assign crop_pixel = '{pix_in.data, cur_col == win.x + 1'b1 && cur_row == win.y + 1'b1,
                         cur_col == win.x + win.w};
   assign pix_ready = fifo_ready;

   always_ff @(posedge clock) begin
      if (reset) begin
         col <= efac_pkg::DIM_W'(1);
         row <= efac_pkg::DIM_W'(1);
      end else if (pix_take) begin
         col <= pix_in.line_end ? efac_pkg::DIM_W'(1) : cur_col + 1'b1;
         row <= pix_in.line_end ? cur_row + 1'b1 : cur_row;
      end
   end

   efac_fifo #(
      .WIDTH($bits(efac_pkg::efac_pixel_type)),
      .DEPTH(efac_pkg::FIFO_DEPTH)
   ) pixel_fifo (
      .clock(clock),
      .reset(reset),
      .in_valid(pix_valid && in_window),
      .in_ready(fifo_ready),
      .in_data(crop_pixel),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_pixel)
   );
endmodule : efac_control
`default_nettype wire

// File: bench/efac_sensor_model.sv
// Pixel array readout model that streams one frame of row/column coded pixels
`default_nettype none
module efac_sensor_model (
   input wire logic clock,
   input wire logic reset,
   input wire logic start,
   input wire logic slow,
   input wire logic [5:0] cols,
   input wire logic [5:0] rows,
   input wire logic pix_ready,
   output logic pix_valid,
   output var efac_pkg::efac_pixel_type pix_in,
   output logic busy
);
   logic [5:0] col;
   logic [5:0] row;
   wire logic wrap = col == cols;
   wire logic last = wrap && row == rows;
   // While pix_valid is low the data lines carry an inverted, useless pattern
   assign pix_in = pix_valid ? {row, col, row == 6'h01 && col == 6'h01, wrap} : {~row, ~col, 2'h3};
   always_ff @(posedge clock) begin
      if (reset) begin
         busy <= 1'b0;
         pix_valid <= 1'b0;
      end else if (!busy) begin
         busy <= start;
         pix_valid <= start;
         col <= 6'h01;
         row <= 6'h01;
      end else if (!pix_valid) begin
         pix_valid <= 1'b1;
      end else if (pix_ready) begin
         busy <= !last;
         pix_valid <= !last && !slow;
         col <= wrap ? 6'h01 : col + 6'h01;
         row <= wrap ? row + 6'h01 : row;
      end
   end
endmodule : efac_sensor_model
`default_nettype wire

// File: bench/efac_monitor.sv
// Port checker for the exposure, frame and window control block
`default_nettype none
module efac_monitor (
   input wire logic clock,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic trigger_in,
   input wire logic exposure_active,
   input wire logic frame_start,
   input wire logic readout_active,
   input wire logic line_done,
   input wire logic pix_valid,
   input wire logic pix_ready,
   input wire efac_pkg::efac_pixel_type pix_in,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire efac_pkg::efac_pixel_type out_pixel
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   logic wr_pend;
   logic [7:0] wr_addr;
   logic [31:0] ctl;
   wire logic [1:0] mode = ctl[1:0];
   wire logic rd_frame = hsel && hready && htrans[1] && !hwrite && haddr == 32'h0000_0008;
   // Shadow of the control register, taken from bus writes
   always_ff @(posedge clock) begin
      if (reset) begin
         wr_pend <= 1'b0;
         ctl <= 32'h0000_0000;
      end else begin
         wr_pend <= hsel && hready && htrans[1] && hwrite && haddr[31:8] == 24'h00_0000;
         wr_addr <= haddr[7:0];
         if (wr_pend && wr_addr == efac_pkg::ADDR_CONTROL)
            ctl <= hwdata;
      end
   end
   a_pulse_follow: assert property (mode == 2'h1 |-> exposure_active == trigger_in)
      else $error("exposure differs from trigger");
   a_off_free: assert property (mode == 2'h0 && frame_start |-> exposure_active)
      else $error("exposure low in free run");
   a_frame_pulse: assert property (frame_start |=> !frame_start)
      else $error("frame start longer than one cycle");
   a_line_pulse: assert property (line_done |=> !line_done ##1 !line_done)
      else $error("line done too close");
   a_line_read: assert property (line_done |-> readout_active)
      else $error("line done outside readout");
   a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_pixel))
      else $error("output pixel changed while stalled");
   a_full_data: assert property ($fell(pix_ready) |-> out_valid)
      else $error("buffer full but no output");
   a_frame_cap: assert property (rd_frame |=> hrdata <= {12'h000, efac_pkg::FRAME_US_MAX})
      else $error("frame time above limit");
   cover property (mode == 2'h1 && exposure_active);
   cover property (!pix_ready);
   cover property (out_valid && out_pixel.first);
endmodule : efac_monitor
bind efac_control efac_monitor i_efac_monitor (.*);
`default_nettype wire

// File: bench/test_exposure_frame_aoi_control.sv
// Testbench for the exposure, frame and window control block
`default_nettype none
module test_exposure_frame_aoi_control;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, trigger_in = 1'b0;
   logic out_ready = 1'b0, start = 1'b0, slow = 1'b0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [5:0] cols = 6'h18, rows = 6'h04;
   wire logic [31:0] hrdata;
   wire logic hready, hreadyout, hresp, exposure_active, frame_start, readout_active, line_done;
   wire logic pix_valid, pix_ready, out_valid, busy;
   wire efac_pkg::efac_pixel_type pix_in, out_pixel;
   int mismatches = 0, n_compared = 0, acc = 0, n, a0;
   assign hready = hreadyout;
   always #25 clock = ~clock;
   always @(posedge clock) if (pix_valid && pix_ready) acc <= acc + 1;
   efac_control i_efac_control (.*);
   efac_sensor_model i_efac_sensor_model (.*);

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         mismatches++;
      end
   endtask : check

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= efac_pkg::HTRANS_NONSEQ;
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0000_0000, r);
      check(r, exp);
   endtask : rd

   function automatic logic sig(input int k);
      return k == 0 ? line_done : frame_start;
   endfunction : sig

   // Cycles from one pulse to the next
   task automatic gap(input int k, output int c);
      do @(posedge clock); while (!sig(k));
      c = 0;
      do begin
         @(posedge clock);
         c++;
      end while (!sig(k));
   endtask : gap

   // Exposure cycles within one whole frame
   task automatic expo(output int c);
      do @(posedge clock); while (!frame_start);
      c = 0;
      do begin
         @(posedge clock);
         if (exposure_active) c++;
      end while (!frame_start);
   endtask : expo

   task automatic collect(input int cnt, input int r0, input int c0, input int w, input logic le);
      out_ready <= 1'b1;
      for (int i = 0; i < cnt; i++) begin
         do @(posedge clock); while (out_valid !== 1'b1);
         check({out_pixel.data, out_pixel.first, out_pixel.line_end & le},
            {6'(r0 + i / w), 6'(c0 + i % w), i == 0, le && i % w == w - 1});
      end
   endtask : collect

   task automatic send(input logic s);
      slow <= s;
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
   endtask : send

   task automatic t_regs;
      rd(efac_pkg::ADDR_EXPOSURE, 32'h0000_2710);
      rd(efac_pkg::ADDR_FRAME, 32'h0001_86A0);
      rd(8'h30, 32'h0000_0000);
      wr(efac_pkg::ADDR_FRAME, 32'h000F_FFFF);
      rd(efac_pkg::ADDR_FRAME, {12'h000, efac_pkg::FRAME_US_MAX});
      wr(efac_pkg::ADDR_PCLK, 32'h0000_0008);
      rd(efac_pkg::ADDR_PCLK, {25'h0, efac_pkg::PCLK_MIN});
   endtask : t_regs

   task automatic t_lines;
      int lt;
      wr(efac_pkg::ADDR_WIN_W, 32'h0000_0040);
      wr(efac_pkg::ADDR_WIN_H, 32'h0000_0002);
      for (int p = 0; p < 4; p++) begin
         lt = p < 2 ? 32 : 64;
         wr(efac_pkg::ADDR_PCLK, 32'(lt));
         // Custom window only, and odd passes set the zero gap
         wr(efac_pkg::ADDR_CONTROL, 32'h0000_0020 | 32'(p % 2) << 3);
         lt = (64 * 20 + lt - 1) / lt + (p % 2 ? 0 : 20);
         gap(1, n);
         gap(1, n);
         check(32'(n), 32'(2 * lt));
         gap(0, n);
         check(32'(n), 32'(lt));
      end
   endtask : t_lines

   task automatic t_frame;
      wr(efac_pkg::ADDR_FRAME, 32'h0000_0032);
      wr(efac_pkg::ADDR_CONTROL, 32'h0000_0024);
      gap(1, n);
      gap(1, n);
      check(32'(n), 32'h0000_03E8);
      rd(efac_pkg::ADDR_PERIOD_US, 32'h0000_0032);
      rd(efac_pkg::ADDR_MAX_EXP, 32'h0000_0032);
      wr(efac_pkg::ADDR_FRAME, 32'h0000_0050);
      gap(1, n);
      rd(efac_pkg::ADDR_MAX_EXP, 32'h0000_0050);
   endtask : t_frame

   task automatic t_expo;
      wr(efac_pkg::ADDR_EXPOSURE, 32'h0000_0014);
      wr(efac_pkg::ADDR_CONTROL, 32'h0000_0026);
      // Exposure opens in the frame start cycle itself
      gap(1, n);
      n = 0;
      do begin
         n++;
         @(posedge clock);
      end while (exposure_active);
      check(32'(n), 32'h0000_0190);
      wr(efac_pkg::ADDR_EXPOSURE, 32'h0000_03E8);
      expo(n);
      check(32'(n), 32'h0000_0640);
      wr(efac_pkg::ADDR_CONTROL, 32'h0000_0024);
      expo(n);
      check(32'(n), 32'h0000_0640);
   endtask : t_expo

   task automatic t_pulse;
      // Trigger input is idle until pulse mode is chosen, and is raised after the control write
      wr(efac_pkg::ADDR_CONTROL, 32'h0000_0025);
      n = 0;
      trigger_in <= 1'b1;
      for (int i = 0; i < 400; i++) begin
         @(posedge clock);
         if (i == 199) trigger_in <= 1'b0;
         if (exposure_active) n++;
      end
      check(32'(n), 32'h0000_00C8);
      rd(efac_pkg::ADDR_PULSE_US, 32'h0000_000A);
   endtask : t_pulse

   task automatic t_window;
      wr(efac_pkg::ADDR_CONTROL, 32'h0000_0020);
      wr(efac_pkg::ADDR_WIN_X, 32'h0000_0008);
      wr(efac_pkg::ADDR_WIN_Y, 32'h0000_0001);
      wr(efac_pkg::ADDR_WIN_W, 32'h0000_0008);
      send(1'b1);
      collect(16, 2, 9, 8, 1'b1);
      // Let the rest of the frame drain before the window widens
      do @(posedge clock); while (busy);
      wr(efac_pkg::ADDR_CONTROL, 32'h0000_0000);
      out_ready <= 1'b0;
      a0 = acc;
      send(1'b0);
      do @(posedge clock); while (pix_ready);
      check(32'(acc - a0), 32'h0000_0020);
      collect(96, 1, 1, 24, 1'b0);
      wr(efac_pkg::ADDR_CONTROL, 32'h0000_0010);
      send(1'b0);
      n = 0;
      repeat (200) begin
         @(posedge clock);
         if (out_valid) n++;
      end
      check(32'(n), 32'h0000_0000);
   endtask : t_window

   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done

   initial begin
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      t_regs;
      t_lines;
      t_frame;
      t_expo;
      t_pulse;
      t_window;
      test_done;
   end

   initial begin
      repeat (90000) @(posedge clock);
      mismatches++;
      test_done;
   end
endmodule : test_exposure_frame_aoi_control
`default_nettype wire
